// File: src/tsi_switch.sv
// time-slot interchange switch core
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module tsi_switch
   import tsi_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // serial streams
   input  wire logic [15:0] serial_in_streams,
   output logic      [15:0] serial_out_streams,
   output logic      [15:0] serial_out_oe_n,
   output logic             control_bit_output,
   // framing and drive control
   input  wire logic        frame_pulse_in,
   input  wire logic        frame_eval_input,
   input  wire logic        wide_pulse_select,
   input  wire logic        output_drive_enable_pin,
   // register port
   input  wire logic [15:0] reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata
);
   typedef struct packed {
      logic [1:0]       rate;
      logic             sev;
      logic             output_standby_bit;
      logic             block_load_trigger_bit;
      logic [4:0]       pat;
      logic             block_program_mode_bit;
      logic [15:0][3:0] ofs;
      logic [11:0]      align;
      logic             done;
      tsi_ev_t          ev;
      logic             fp_l;
      logic [2:0]       run;
      logic             gci;
      logic             fe_l;
      logic [1:0]       ph;
      logic [9:0]       bcnt;
      logic [1:0]       bank;
      logic [15:0][7:0] rxsr;
      logic [15:0][7:0] hold;
      logic [6:0]       hch;
      logic [1:0]       hbank;
      logic [15:0][7:0] stage;
      logic [15:0][7:0] tsr;
      logic [15:0]      s_oe;
      logic [15:0]      s_lb;
      logic [15:0]      c_oe;
      logic [15:0]      c_lb;
      logic [15:0]      oe_n;
      logic             ctl;
      logic             fill;
      logic [10:0]      fidx;
      logic [15:0]      rdata;
   } tsi_st_t;

   tsi_st_t     q;
   tsi_st_t     d;
   logic [15:0] cmem [0:2047];
   logic [7:0]  dmem [0:6143];
   logic [15:0] skew_out;
   logic [4:0]  cyc;
   logic [6:0]  ch;
   logic [6:0]  nch;
   logic [6:0]  lastc;
   logic [9:0]  endbit;
   logic        fs;
   logic        fw;
   logic        fe_edge;
   logic        glob;
   logic [3:0]  k;
   logic [15:0] cm;
   logic [1:0]  rb;
   logic [1:0]  refb;
   logic [7:0]  byte_v;
   logic        cm_we;
   logic [10:0] cm_wa;
   logic [15:0] cm_wd;
   logic        dm_we;
   logic [12:0] dm_wa;
   logic [3:0]  ws;
   logic        rbit;

   function automatic logic [6:0] last_ch(input logic [1:0] r);
      return r[1] ? LAST_CH_8M : (r[0] ? LAST_CH_4M : LAST_CH_2M);
   endfunction

   function automatic logic [1:0] bk(input logic [1:0] b, input logic [1:0] n);
      logic [2:0] t;
      t = {1'b0, b} + {1'b0, n};
      return (t >= 3'h3) ? 2'(t - 3'h3) : t[1:0];
   endfunction

   genvar gs;
   generate
      for (gs = 0; gs < NSTR; gs++) begin : g_str
         tsi_skew u_skew (
            .clk     (clk),
            .reset_n (reset_n),
            .din     (serial_in_streams[gs]),
            .sel     (q.ofs[gs]),
            .dout    (skew_out[gs])
         );
         assign serial_out_streams[gs] = q.tsr[gs][7];
      end
   endgenerate

   always_comb begin
      d = q;
      rbit = 1'b0;
      cyc = {q.bcnt[2:0], q.ph};
      ch = q.bcnt[9:3];
      lastc = last_ch(q.rate);
      endbit = {lastc, 3'h7};
      nch = (ch >= lastc) ? 7'h0 : 7'(ch + 7'h1);
      // frame pulse detection and format classification
      fs = 1'b0;
      d.fp_l = frame_pulse_in;
      if (frame_pulse_in != q.fp_l) begin
         d.run = 3'h0;
         if (wide_pulse_select) begin
            fs = frame_pulse_in;
            d.gci = 1'b0;
         end else if (q.run < PULSE_MAX) begin
            fs = 1'b1;
            d.gci = q.fp_l;
         end
      end else if (q.run != 3'h7) begin
         d.run = 3'(q.run + 3'h1);
      end
      // bit and channel timing, four clocks per bit
      fw = fs | ((q.ph == PH_SAMPLE) && (q.bcnt >= endbit));
      if (fs) begin
         d.ph = 2'h0;
         d.bcnt = 10'h0;
      end else begin
         d.ph = 2'(q.ph + 2'h1);
         if (q.ph == PH_SAMPLE) begin
            d.bcnt = (q.bcnt >= endbit) ? 10'h0 : 10'(q.bcnt + 10'h1);
         end
      end
      if (fw) begin
         d.bank = bk(q.bank, 2'h1);
      end
      // receive shift, one sample per bit
      if (q.ph == PH_SAMPLE) begin
         for (int s = 0; s < NSTR; s++) begin
            rbit = q.c_lb[s] ? q.tsr[s][7] : skew_out[s];
            d.rxsr[s] = {q.rxsr[s][6:0], rbit};
         end
      end
      if (cyc == 5'h0) begin
         d.hold = q.rxsr;
         d.hch = (ch == 7'h0) ? lastc : 7'(ch - 7'h1);
         d.hbank = (ch == 7'h0) ? bk(q.bank, 2'h2) : q.bank;
      end
      ws = 4'(cyc - 5'h1);
      dm_we = (cyc >= 5'h1) && (cyc <= CYC_WR_LAST);
      dm_wa = {q.hbank, ws, q.hch};
      // fetch for the next channel, one stream a cycle
      k = cyc[3:0];
      cm = cmem[{k, nch}];
      refb = (nch == 7'h0) ? bk(q.bank, 2'h1) : q.bank;
      if (cm[C_CD]) begin
         rb = bk(refb, 2'h1);
      end else if (({1'b0, cm[6:0]} + 8'h3) <= {1'b0, nch}) begin
         rb = refb;
      end else begin
         rb = bk(refb, 2'h2);
      end
      byte_v = cm[C_PC] ? cm[7:0] : dmem[{rb, cm[10:0]}];
      if (!cyc[4]) begin
         d.stage[k] = byte_v;
         d.s_oe[k] = cm[C_OE];
         d.s_lb[k] = cm[C_LB];
         d.ctl = cm[C_CC];
      end
      // parallel load at channel end, shift at bit end
      if (cyc == CYC_LAST) begin
         d.tsr = q.stage;
         d.c_oe = q.s_oe;
         d.c_lb = q.s_lb;
      end else if (q.ph == PH_SAMPLE) begin
         for (int s = 0; s < NSTR; s++) begin
            d.tsr[s] = {q.tsr[s][6:0], 1'b0};
         end
      end
      glob = output_drive_enable_pin | q.output_standby_bit;
      d.oe_n = ~({16{glob}} & d.c_oe);
      // block fill engine
      if (q.fill) begin
         d.fidx = 11'(q.fidx + 11'h1);
         if (q.fidx == FILL_LAST) begin
            d.fill = 1'b0;
            d.block_load_trigger_bit = 1'b0;
         end
      end else if (q.block_program_mode_bit && q.block_load_trigger_bit) begin
         d.fill = 1'b1;
         d.fidx = 11'h0;
      end
      cm_we = 1'b0;
      cm_wa = reg_addr[10:0];
      cm_wd = reg_wdata;
      if (q.fill) begin
         cm_we = 1'b1;
         cm_wa = q.fidx;
         cm_wd = {q.pat, 11'h0};
      end else if (reg_wr && (reg_addr[15:14] == SP_CMEM)) begin
         cm_we = 1'b1;
      end
      // register writes
      if (reg_wr && (reg_addr[15:14] == SP_REG)) begin
         if (reg_addr[7:0] == R_MODE) begin
            d.rate = reg_wdata[M_RATE +: 2];
            d.sev = reg_wdata[M_SEV];
            d.output_standby_bit = reg_wdata[M_OSB];
            d.block_load_trigger_bit = reg_wdata[M_BPE];
            d.pat = reg_wdata[M_PAT +: 5];
         end else if (reg_addr[7:0] == R_CTRL) begin
            d.block_program_mode_bit = reg_wdata[0];
         end else if (reg_addr[7:4] == R_OFS_HI) begin
            d.ofs[reg_addr[3:0]] = (reg_wdata[3:0] > OFS_MAX) ? OFS_MAX : reg_wdata[3:0];
         end
      end
      // frame offset evaluation
      fe_edge = q.gci ? (frame_eval_input & ~q.fe_l) : (~frame_eval_input & q.fe_l);
      d.fe_l = frame_eval_input;
      case (q.ev)
         EV_IDLE: begin
            if (d.sev && !q.sev) begin
               d.ev = EV_ARM;
               d.done = 1'b0;
            end
         end
         EV_ARM: begin
            if (fw) begin
               d.ev = EV_MEAS;
            end
         end
         EV_MEAS: begin
            if (fe_edge) begin
               d.align = {q.bcnt, q.ph};
            end
            if (fw) begin
               d.ev = EV_DONE;
               d.done = 1'b1;
            end
         end
         EV_DONE: begin
            d.ev = EV_DONE;
         end
         default: begin
            d.ev = EV_IDLE;
         end
      endcase
      if (!d.sev || wide_pulse_select) begin
         d.ev = EV_IDLE;
      end
      // read data, valid the cycle after the strobe only
      d.rdata = 16'h0;
      if (reg_rd) begin
         case (reg_addr[15:14])
            SP_REG: begin
               if (reg_addr[7:0] == R_MODE) begin
                  d.rdata = {6'h0, q.pat, q.block_load_trigger_bit, q.output_standby_bit, q.sev, q.rate};
               end else if (reg_addr[7:0] == R_CTRL) begin
                  d.rdata = {15'h0, q.block_program_mode_bit};
               end else if (reg_addr[7:0] == R_ALIGN) begin
                  d.rdata = {3'h0, q.done, q.align};
               end else if (reg_addr[7:4] == R_OFS_HI) begin
                  d.rdata = {12'h0, q.ofs[reg_addr[3:0]]};
               end
            end
            SP_CMEM: begin
               d.rdata = cmem[reg_addr[10:0]];
            end
            SP_DMEM: begin
               d.rdata = {8'h0, dmem[{bk(q.bank, 2'h2), reg_addr[10:0]}]};
            end
            default: begin
               d.rdata = 16'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
         q.oe_n <= 16'hffff;
         q.ev <= EV_IDLE;
         q.fp_l <= 1'b1;
         q.fe_l <= 1'b1;
         q.run <= 3'h7;
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge clk) begin
      if (cm_we) begin
         cmem[cm_wa] <= cm_wd;
      end
      if (dm_we) begin
         dmem[dm_wa] <= q.hold[ws];
      end
   end

   assign serial_out_oe_n = q.oe_n;
   assign control_bit_output = q.ctl;
   assign reg_rdata = q.rdata;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   a_frame_len: assert property ((q.bcnt <= endbit) |=> q.bcnt <= {last_ch($past(q.rate)), 3'h7})
      else $error("bit counter ran past frame end");
   a_hold_capture: assert property ((cyc == 5'h0) |=> q.hold == $past(q.rxsr))
      else $error("received bytes not captured at channel start");
   a_tx_load: assert property ((cyc == CYC_LAST) |=> (q.tsr == $past(q.stage)) && (q.c_oe == $past(q.s_oe)))
      else $error("output shift registers not loaded at channel end");
   a_proc_byte: assert property (!cyc[4] && cm[C_PC] |=> q.stage[$past(k)] == $past(cm[7:0]))
      else $error("processor byte not staged");
   a_ch_tristate: assert property (output_drive_enable_pin && (cyc == CYC_LAST) |=> q.oe_n == ~q.c_oe)
      else $error("per-channel enable not applied");
   a_global_off: assert property (!output_drive_enable_pin && !q.output_standby_bit |=> &q.oe_n)
      else $error("outputs driven while globally disabled");
   a_wide_no_eval: assert property (wide_pulse_select |=> (q.ev == EV_IDLE))
      else $error("evaluation active in wide pulse mode");
   a_eval_done: assert property ($rose(q.done) |-> ($past(q.ev) == EV_MEAS) && $past(fw))
      else $error("done flag raised outside a frame boundary");
   a_align_read: assert property (reg_rd && (reg_addr == {SP_REG, 6'h0, R_ALIGN}) |=>
                                  reg_rdata == {3'h0, $past(q.done), $past(q.align)})
      else $error("alignment result read back wrong");
   a_fill_word: assert property (q.fill |-> cm_we && (cm_wa == q.fidx) && (cm_wd[10:0] == 11'h0))
      else $error("block fill word wrong");
   a_fill_clear: assert property (q.fill && (q.fidx == FILL_LAST) && !reg_wr |=> !q.fill && !q.block_load_trigger_bit)
      else $error("block load trigger not cleared after fill");
   c_fill_done: cover property (q.fill ##1 !q.fill);
   c_eval_done: cover property ($rose(q.done));
   c_gci_seen: cover property ($rose(q.gci));
   c_loopback: cover property (|q.c_lb);
endmodule

// File: src/tsi_pkg.sv
// constants and types of the time-slot interchange switch core
// Operation
// - frames of 32, 64 or 128 byte channels
// - input and output share one bit rate
// - received channels stored sequentially in data memory
// - output byte fetched one time-slot early
// - connection fields select source stream and channel
// - processor byte repeats every frame
// - per-channel enable tristates that channel only
// - global disable overrides per-channel enables
// - wide pulse select or frame format autodetect
// - bit boundary and three-quarter sampling point
// - wide mode disables measurement, keeps offsets
// - rate bits pick 32, 64, 128 channels
// - per-stream input delay up to eight clock periods
// - done flag and offset two frames later
// - edge pairing follows detected frame format
// - block fill copies pattern into bits 15:11
// - fill zeroes bits 10:0, then self-clears trigger
// - loopback feeds output into same input slot
// - drive pin forces enable, else standby bit
// - processor bit picks memory byte source
// - variable delay at least three time-slots
// - constant delay reads frame n+2
package tsi_pkg;
   localparam int NSTR = 16;
   localparam logic [1:0] PH_SAMPLE = 2'h3;
   localparam logic [4:0] CYC_LAST = 5'h1f;
   localparam logic [4:0] CYC_WR_LAST = 5'h10;
   localparam logic [2:0] PULSE_MAX = 3'h6;
   localparam logic [3:0] OFS_MAX = 4'h8;
   localparam logic [10:0] FILL_LAST = 11'h7ff;
   localparam logic [6:0] LAST_CH_2M = 7'h1f;
   localparam logic [6:0] LAST_CH_4M = 7'h3f;
   localparam logic [6:0] LAST_CH_8M = 7'h7f;
   localparam logic [1:0] SP_REG = 2'h0;
   localparam logic [1:0] SP_CMEM = 2'h2;
   localparam logic [1:0] SP_DMEM = 2'h3;
   localparam logic [7:0] R_MODE = 8'h00;
   localparam logic [7:0] R_CTRL = 8'h01;
   localparam logic [7:0] R_ALIGN = 8'h02;
   localparam logic [3:0] R_OFS_HI = 4'h1;
   localparam int M_RATE = 0;
   localparam int M_SEV = 2;
   localparam int M_OSB = 3;
   localparam int M_BPE = 4;
   localparam int M_PAT = 5;
   localparam int A_DONE = 12;
   localparam int C_PC = 11;
   localparam int C_OE = 12;
   localparam int C_CD = 13;
   localparam int C_LB = 14;
   localparam int C_CC = 15;
   typedef enum logic [3:0] {
      EV_IDLE = 4'h1,
      EV_ARM  = 4'h2,
      EV_MEAS = 4'h4,
      EV_DONE = 4'h8
   } tsi_ev_t;
endpackage

// File: src/tsi_skew.sv
// per-stream input delay line in whole master clock steps
`timescale 1ns/1ps
module tsi_skew
   import tsi_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       reset_n,
   // stream and delay select
   input  wire logic       din,
   input  wire logic [3:0] sel,
   output logic            dout
);
   typedef struct packed {
      logic [8:1] tap;
   } tsi_sk_t;

   tsi_sk_t q;
   tsi_sk_t d;

   always_comb begin
      d = q;
      d.tap = {q.tap[7:1], din};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dout = (sel == 4'h0) ? din : q.tap[sel];
endmodule

// File: tb/tsi_stream_src.sv
// far-side serial stream source: frame pulse, input streams, evaluation input
`timescale 1ns/1ps
module tsi_stream_src (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // frame pulse format
   input  wire logic        gci,
   // serial side
   output logic      [15:0] serial_in_streams,
   output logic             frame_pulse_in,
   output logic             frame_eval_input,
   // frame position
   output logic      [9:0]  cnt,
   output logic      [7:0]  frm
);
   logic [9:0] pos;
   logic [7:0] pfrm;
   logic [7:0] tmp;

   function automatic logic [7:0] src_byte(input int s, input int c, input logic [7:0] f);
      return 8'(s * 29) ^ 8'(c * 7) ^ f;
   endfunction

   // 32 channels of 8 bits, 4 clocks a bit
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 10'h000;
         frm <= 8'h00;
      end else begin
         cnt <= cnt + 10'h001;
         if (cnt == 10'h3ff) begin
            frm <= frm + 8'h01;
         end
      end
   end

   // bits change one clock after the bit start, stable over the sample point
   assign pos  = cnt - 10'h001;
   assign pfrm = frm - {7'h00, cnt == 10'h000};
   always_comb begin
      for (int s = 0; s < 16; s++) begin
         tmp = src_byte(s, int'(pos[9:5]), pfrm);
         serial_in_streams[s] = tmp[3'h7 - pos[4:2]];
      end
   end

   // short pulse before frame start, low in falling format, high in gci format
   assign frame_pulse_in   = gci ^ (cnt < 10'h3fe);
   assign frame_eval_input = gci ^ (cnt < 10'h200);
endmodule

// File: tb/test_tsi_switch.sv
// self-checking bench of the time-slot interchange switch core
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
   $display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end
module test_tsi_switch
   import tsi_pkg::*;
;
   logic        clk, reset_n, frame_pulse_in, frame_eval_input, output_drive_enable_pin;
   logic        reg_wr, reg_rd, control_bit_output;
   logic        gci_mode, wide_pulse_select;
   logic [15:0] serial_in_streams, serial_out_streams, serial_out_oe_n;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [9:0]  pcnt;
   logic [7:0]  pfrm, b, f;
   logic        oe;
   int          fails, samples_checked, seed, s, c, n;
   int          cs[4][6] = '{'{4, 2, 7, 10, 0, 0}, '{9, 10, 7, 11, 0, 1}, '{4, 5, 2, 20, 1, 2}, '{4, 2, 12, 3, 0, 1}};

   tsi_switch uut (.clk(clk), .reset_n(reset_n), .serial_in_streams(serial_in_streams),
      .serial_out_streams(serial_out_streams), .serial_out_oe_n(serial_out_oe_n),
      .control_bit_output(control_bit_output), .frame_pulse_in(frame_pulse_in),
      .frame_eval_input(frame_eval_input), .wide_pulse_select(wide_pulse_select),
      .output_drive_enable_pin(output_drive_enable_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   tsi_stream_src src (.clk(clk), .reset_n(reset_n), .serial_in_streams(serial_in_streams),
      .gci(gci_mode), .frame_pulse_in(frame_pulse_in), .frame_eval_input(frame_eval_input), .cnt(pcnt), .frm(pfrm));

   function automatic logic [7:0] exp_byte(input int s, input int c, input logic [7:0] f);
      return 8'(s * 29) ^ 8'(c * 7) ^ f;
   endfunction

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] v);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] v);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      @(posedge clk);
      v = reg_rdata;
   endtask

   // capture one output byte of stream st, channel ch, mid-bit
   task automatic cap(input int st, input int ch, output logic [7:0] by, output logic en, output logic [7:0] fr);
      int i;
      i = 0;
      while (pcnt !== 10'(ch * 32 + 2) && i < 2100) begin
         @(posedge clk);
         i++;
      end
      if (i >= 2100) begin
         fails++;
         complete_run();
      end
      fr = pfrm;
      en = serial_out_oe_n[st];
      for (i = 0; i < 8; i++) begin
         by[7 - i] = serial_out_streams[st];
         if (i < 7) repeat (4) @(posedge clk);
      end
   endtask

   always #25 clk = ~clk;

   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      complete_run();
   end

   initial begin
      clk = 1'b0;
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      output_drive_enable_pin = 1'b0;
      gci_mode = 1'b0;
      wide_pulse_select = 1'b0;
      seed = 32'h5142;
      fails = 0;
      samples_checked = 0;
      repeat (8) @(posedge clk);
      `CHK(serial_out_oe_n, 16'hffff)
      reset_n <= 1'b1;
      @(posedge clk);
      for (n = 0; n < 4; n++) begin
         wr({8'h00, R_MODE}, 16'(n));
         rd({8'h00, R_MODE}, d);
         `CHK(d[1:0], 2'(n))
      end
      wr(16'h0013, 16'h0005);
      rd(16'h0013, d);
      `CHK(d[3:0], 4'h5)
      wr(16'h0013, 16'h0000);
      wr({8'h00, R_ALIGN}, 16'hffff);
      rd({8'h00, R_ALIGN}, d);
      `CHK(d[12], 1'b0)
      rd(16'h0005, d);
      `CHK(d, 16'h0000)
      rd({8'h00, R_MODE}, d);
      @(posedge clk);
      `CHK(reg_rdata, 16'h0000)
      wr({8'h00, R_CTRL}, 16'h0001);
      wr({8'h00, R_MODE}, 16'h0290);
      for (n = 0; n < 40; n++) begin
         repeat (60) @(posedge clk);
         rd({8'h00, R_MODE}, d);
         if (d[M_BPE] === 1'b0) break;
      end
      `CHK(d[M_BPE], 1'b0)
      `CHK(n * 62 < 2200, 1'b1)
      for (n = 0; n < 4; n++) begin
         rd(16'h8000 | 16'($random(seed) & 32'h7ff), d);
         `CHK(d, 16'ha000)
      end
      wr({8'h00, R_CTRL}, 16'h0000);
      `CHK(serial_out_oe_n, 16'hffff)
      repeat (32) @(posedge clk);
      `CHK(control_bit_output, 1'b1)
      wr({8'h00, R_MODE}, 16'h0008);
      s = $unsigned($random(seed)) % 16;
      c = $unsigned($random(seed)) % 32;
      cap(s, c ^ 1, b, oe, f);
      `CHK(oe, 1'b1)
      output_drive_enable_pin <= 1'b1;
      d = 16'h1800 | 16'($random(seed) & 32'hff);
      wr(16'h8000 | 16'(s * 128 + c), d);
      repeat (1024) @(posedge clk);
      for (n = 0; n < 2; n++) begin
         cap(s, c, b, oe, f);
         `CHK(b, d[7:0])
         `CHK(oe, 1'b0)
      end
      cap(s, c ^ 1, b, oe, f);
      `CHK(oe, 1'b1)
      output_drive_enable_pin <= 1'b0;
      wr({8'h00, R_MODE}, 16'h0000);
      cap(s, c, b, oe, f);
      `CHK(oe, 1'b1)
      output_drive_enable_pin <= 1'b1;
      cap(s, c, b, oe, f);
      `CHK(oe, 1'b0)
      wr({8'h00, R_MODE}, 16'h0008);
      for (n = 0; n < 4; n++) begin
         wr(16'h8000 | 16'(cs[n][2] * 128 + cs[n][3]), 16'h1000 | 16'(cs[n][4] * 8192 + cs[n][0] * 128 + cs[n][1]));
      end
      repeat (3072) @(posedge clk);
      for (n = 0; n < 4; n++) begin
         cap(cs[n][2], cs[n][3], b, oe, f);
         `CHK(b, exp_byte(cs[n][0], cs[n][1], f - 8'(cs[n][5])))
      end
      repeat (1100) @(posedge clk);
      wr({8'h00, R_MODE}, 16'h000c);
      repeat (500) @(posedge clk);
      rd({8'h00, R_ALIGN}, d);
      `CHK(d[12], 1'b0)
      repeat (1700) @(posedge clk);
      rd({8'h00, R_ALIGN}, d);
      `CHK(d[12], 1'b1)
      `CHK(d[11:0] > 12'd505 && d[11:0] < 12'd518, 1'b1)
      d = 16'h5800 | 16'($random(seed) & 32'hff);
      wr(16'h8000 | 16'(6 * 128 + 4), d);
      wr(16'h8000 | 16'(8 * 128 + 9), 16'h1304);
      repeat (2048) @(posedge clk);
      cap(8, 9, b, oe, f);
      `CHK(b, d[7:0])
      gci_mode <= 1'b1;
      wr({8'h00, R_MODE}, 16'h0008);
      repeat (1100) @(posedge clk);
      wr({8'h00, R_MODE}, 16'h000c);
      repeat (2300) @(posedge clk);
      rd({8'h00, R_ALIGN}, d);
      `CHK(d[12], 1'b1)
      `CHK(d[11:0] > 12'd505 && d[11:0] < 12'd518, 1'b1)
      wide_pulse_select <= 1'b1;
      gci_mode <= 1'b0;
      wr(16'h0015, 16'h0008);
      wr(16'h8000 | 16'(3 * 128 + 20), 16'h1000 | 16'(5 * 128 + 12));
      wr({8'h00, R_MODE}, 16'h0008);
      repeat (1100) @(posedge clk);
      wr({8'h00, R_MODE}, 16'h000c);
      repeat (2300) @(posedge clk);
      cap(3, 20, b, oe, f);
      `CHK(b, 8'({exp_byte(5, 11, f), exp_byte(5, 12, f)} >> 2))
      rd({8'h00, R_ALIGN}, d);
      `CHK(d[12], 1'b0)
      complete_run();
   end
endmodule
